//--- verilog/nvm_defines.svh
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define CTRL_OFFSET      12'h01c
`define ARRAY_BASE       12'h100
`define ARRAY_BYTES      160
`define ARRAY_LAST       12'h19f
`define BLOCK_BYTES      32
`define CTRL_RESET       8'h00
`define CTRL_WMASK       8'h5f
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_PUMP         6
`define BIT_ERASE_HI     4
`define BIT_ERASE_LO     3
`define BIT_LATCH        2
`define BIT_RC           1
`define BIT_POWER        0
`define ERASED_BYTE      8'hff
`endif

//--- verilog/nvm_pkg.sv
`default_nettype none
package nvm_pkg;
	typedef enum logic [1:0] {
		ERASE_NONE  = 2'b00,
		ERASE_BYTE  = 2'b01,
		ERASE_BLOCK = 2'b10,
		ERASE_BULK  = 2'b11
	} erase_mode_t;
	typedef struct packed {
		logic       pump_enable;
		logic [1:0] erase_select;
		logic       array_latch_control;
		logic       rc_clock_select;
		logic       array_power_enable;
	} ctrl_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} target_t;
endpackage : nvm_pkg
`default_nettype wire

//--- verilog/nvm_program_control.sv
// Contract
// - pump_enable bit 6 switches charge pump on; off when clear
// - erase field 00 program, 01 byte, 10 block, 11 bulk
// - byte erase clears only the addressed byte
// - block erase clears aligned 32-byte block holding the address
// - bulk erase clears all 160 bytes
// - latch bit routes buses to programming and blocks array reads
// - rc_clock_select bit 1 picks internal RC clock over CPU clock
// - power enable applies pump voltage to array; clear removes it
// - array is 160 bytes from 0x0100, on-chip programming voltage
// - erased reads one; program only drives written zeros low
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_defines.svh"
module nvm_program_control (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             pump_on,
	output logic             array_power_on,
	output logic             rc_clock_on
);
	import nvm_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic in_array(input logic [11:0] a);
		return (a >= `ARRAY_BASE) && (a <= `ARRAY_LAST);
	endfunction : in_array

	function automatic logic [7:0] array_index(input logic [11:0] a);
		logic [11:0] d;
		d = a - `ARRAY_BASE;
		return d[7:0];
	endfunction : array_index

	function automatic ctrl_t ctrl_from_byte(input logic [7:0] b);
		logic [7:0] m;
		m = b & `CTRL_WMASK;
		return '{pump_enable: m[`BIT_PUMP],
			erase_select: m[`BIT_ERASE_HI:`BIT_ERASE_LO],
			array_latch_control: m[`BIT_LATCH],
			rc_clock_select: m[`BIT_RC],
			array_power_enable: m[`BIT_POWER]};
	endfunction : ctrl_from_byte

	function automatic logic [7:0] ctrl_to_byte(input ctrl_t c);
		logic [7:0] b;
		b = 8'h00;
		b[`BIT_PUMP] = c.pump_enable;
		b[`BIT_ERASE_HI:`BIT_ERASE_LO] = c.erase_select;
		b[`BIT_LATCH] = c.array_latch_control;
		b[`BIT_RC] = c.rc_clock_select;
		b[`BIT_POWER] = c.array_power_enable;
		return b;
	endfunction : ctrl_to_byte

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]  mem_ff [0:`ARRAY_BYTES-1];
	logic [7:0]  nxt_mem [0:`ARRAY_BYTES-1];
	ctrl_t       ctrl_ff,   nxt_ctrl;
	target_t     tgt_ff,    nxt_tgt;
	logic        aw_ff,     nxt_aw;
	logic        w_ff,      nxt_w;
	logic [11:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff,  nxt_wdata;
	logic [3:0]  wstrb_ff,  nxt_wstrb;
	logic        bvalid_ff, nxt_bvalid;
	logic [1:0]  bresp_ff,  nxt_bresp;
	logic        rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff,  nxt_rdata;
	logic [1:0]  rresp_ff,  nxt_rresp;
	logic        do_write;
	logic        active;

	assign s_axi_awready = !aw_ff && !bvalid_ff;
	assign s_axi_wready  = !w_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign pump_on        = ctrl_ff.pump_enable;
	assign array_power_on = ctrl_ff.array_power_enable;
	assign rc_clock_on    = ctrl_ff.rc_clock_select;
	assign active = ctrl_ff.array_latch_control && ctrl_ff.pump_enable
		&& ctrl_ff.array_power_enable;

	// ----------------------------------------
	// write channel and control register
	// ----------------------------------------
	always_comb begin
		nxt_aw     = aw_ff || (s_axi_awvalid && s_axi_awready);
		nxt_w      = w_ff || (s_axi_wvalid && s_axi_wready);
		nxt_awaddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr
			: awaddr_ff;
		nxt_wdata  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata
			: wdata_ff;
		nxt_wstrb  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb
			: wstrb_ff;
		nxt_bvalid = bvalid_ff && !s_axi_bready;
		nxt_bresp  = bresp_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_tgt    = tgt_ff;
		do_write   = aw_ff && w_ff && !bvalid_ff;
		if (do_write) begin
			nxt_aw     = 1'b0;
			nxt_w      = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = 2'b00;
			if ({awaddr_ff[11:2], 2'b00} == `CTRL_OFFSET) begin
				if (wstrb_ff[0]) begin
					nxt_ctrl = ctrl_from_byte(wdata_ff[7:0]);
				end
			end else if (in_array(awaddr_ff)) begin
				// only bytes lane 0 carries array data
				if (ctrl_ff.array_latch_control && wstrb_ff[0]) begin
					nxt_tgt = '{valid: 1'b1,
						addr: array_index(awaddr_ff),
						data: wdata_ff[7:0]};
				end
			end else begin
				nxt_bresp = 2'b10;
			end
		end
		if (!ctrl_ff.array_latch_control) begin
			nxt_tgt.valid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'b00;
			ctrl_ff   <= ctrl_from_byte(`CTRL_RESET);
			tgt_ff    <= '0;
		end else begin
			aw_ff     <= nxt_aw;
			w_ff      <= nxt_w;
			awaddr_ff <= nxt_awaddr;
			wdata_ff  <= nxt_wdata;
			wstrb_ff  <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			ctrl_ff   <= nxt_ctrl;
			tgt_ff    <= nxt_tgt;
		end
	end

	// ----------------------------------------
	// array program and erase
	// ----------------------------------------
	always_comb begin
		nxt_mem = mem_ff;
		if (active && tgt_ff.valid) begin
			for (int i = 0; i < `ARRAY_BYTES; i++) begin
				case (erase_mode_t'(ctrl_ff.erase_select))
				ERASE_NONE: begin
					if (i == int'(tgt_ff.addr))
						nxt_mem[i] = mem_ff[i] & tgt_ff.data;
				end
				ERASE_BYTE: begin
					if (i == int'(tgt_ff.addr))
						nxt_mem[i] = `ERASED_BYTE;
				end
				ERASE_BLOCK: begin
					if (i / `BLOCK_BYTES
						== int'(tgt_ff.addr) / `BLOCK_BYTES)
						nxt_mem[i] = `ERASED_BYTE;
				end
				default: begin
					nxt_mem[i] = `ERASED_BYTE;
				end
				endcase
			end
		end
	end

	// nonvolatile: contents survive reset
	always_ff @(posedge aclk) begin
		mem_ff <= nxt_mem;
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_comb begin
		nxt_rvalid = rvalid_ff && !s_axi_rready;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = 2'b00;
			nxt_rdata  = 32'h0000_0000;
			if ({s_axi_araddr[11:2], 2'b00} == `CTRL_OFFSET) begin
				nxt_rdata[7:0] = ctrl_to_byte(ctrl_ff);
			end else if (in_array(s_axi_araddr)) begin
				if (ctrl_ff.array_latch_control) begin
					nxt_rresp = 2'b10;
				end else begin
					nxt_rdata[7:0] = mem_ff[array_index(s_axi_araddr)];
				end
			end else begin
				nxt_rresp = 2'b10;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= 2'b00;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end
	end
endmodule : nvm_program_control
`default_nettype wire

//--- verification/nvm_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_ctrl_properties (
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic [11:0]	s_axi_awaddr,
	input wire logic [31:0]	s_axi_wdata,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic [11:0]	s_axi_araddr,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic	s_axi_rvalid,
	input wire logic	pump_on,
	input wire logic	array_power_on,
	input wire logic	rc_clock_on
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	pump_follow_a: assert property ($rose(s_axi_bvalid) &&
		$past(s_axi_awaddr) == 12'h01c |-> pump_on == $past(s_axi_wdata[6]))
		else $error("pump bit");
	power_follow_a: assert property ($rose(s_axi_bvalid) &&
		$past(s_axi_awaddr) == 12'h01c
		|-> array_power_on == $past(s_axi_wdata[0])) else $error("power bit");
	rc_follow_a: assert property ($rose(s_axi_bvalid) &&
		$past(s_axi_awaddr) == 12'h01c
		|-> rc_clock_on == $past(s_axi_wdata[1])) else $error("rc bit");
	outputs_hold_a: assert property (!$rose(s_axi_bvalid)
		|-> $stable({pump_on, array_power_on, rc_clock_on}))
		else $error("outputs moved");
	ctrl_okay_a: assert property ($rose(s_axi_bvalid) &&
		$past(s_axi_awaddr) == 12'h01c |-> s_axi_bresp == 2'h0)
		else $error("ctrl bresp");
	unmapped_err_a: assert property ($rose(s_axi_bvalid) &&
		$past(s_axi_awaddr) == 12'h020 |-> s_axi_bresp == 2'h2)
		else $error("unmapped bresp");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|-> ##[1:2] s_axi_rvalid) else $error("no rvalid");
	ctrl_read_a: assert property ($rose(s_axi_rvalid) &&
		$past(s_axi_araddr) == 12'h01c
		|-> s_axi_rdata[31:8] == 24'h000000 && s_axi_rdata[7] == 1'h0
		&& s_axi_rdata[5] == 1'h0) else $error("ctrl read bits");
endmodule : nvm_ctrl_properties
bind nvm_program_control nvm_ctrl_properties chk (.aclk, .aresetn,
	.s_axi_awaddr, .s_axi_wdata, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pump_on,
	.array_power_on, .rc_clock_on);
`default_nettype wire

//--- verification/eeprom_program_erase_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_program_erase_control_tb_top;
	logic	aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
	logic	s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic	s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic	s_axi_arready, s_axi_rvalid, pump_on, array_power_on, rc_clock_on;
	logic [11:0]	s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0]	s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]	s_axi_wstrb = 4'h1;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	int	errors = 0, comparisons = 0;
	nvm_program_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pump_on,
		.array_power_on, .rc_clock_on);
	always #20 aclk = ~aclk;
	task automatic print_verdict();
		if (errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	task automatic cmp(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task automatic wr(input logic [11:0] a, input logic [7:0] d,
			input logic [1:0] r);
		int n;
		logic aw_done, w_done;
		n = 0;
		aw_done = 1'h0;
		w_done = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw_done && w_done) && n < 50) begin
			@(posedge aclk);
			n++;
			if (!aw_done && s_axi_awready === 1'h1) begin
				aw_done = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w_done && s_axi_wready === 1'h1) begin
				w_done = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_bvalid !== 1'h1 && n < 100);
		if (s_axi_bvalid !== 1'h1) begin
			cmp("bvalid", 32'h1, {31'h0, s_axi_bvalid});
			print_verdict();
		end
		cmp("bresp", r, s_axi_bresp);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e,
			input logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_arready !== 1'h1 && n < 50);
		s_axi_arvalid <= 1'h0;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_rvalid !== 1'h1 && n < 100);
		if (s_axi_rvalid !== 1'h1) begin
			cmp("rvalid", 32'h1, {31'h0, s_axi_rvalid});
			print_verdict();
		end
		cmp("rresp", r, s_axi_rresp);
		cmp("rdata", {24'h000000, e}, s_axi_rdata);
	endtask : rd
	task automatic op(input logic [1:0] m, input logic [11:0] a,
			input logic [7:0] d);
		logic [7:0] c;
		c = {3'h2, m, 3'h4};
		wr(12'h01c, c, 2'h0);
		wr(a, d, 2'h0);
		wr(12'h01c, c | 8'h01, 2'h0);
		cmp("power", 1'h1, array_power_on);
		cmp("pump", 1'h1, pump_on);
		wr(12'h01c, c, 2'h0);
		cmp("power", 1'h0, array_power_on);
		rd(a, 8'h00, 2'h2);
		wr(12'h01c, 8'h00, 2'h0);
		cmp("pump", 1'h0, pump_on);
	endtask : op
	task automatic t_regs();
		rd(12'h01c, 8'h00, 2'h0);
		wr(12'h01c, 8'hff, 2'h0);
		rd(12'h01c, 8'h5f, 2'h0);
		cmp("pump", 1'h1, pump_on);
		cmp("rc", 1'h1, rc_clock_on);
		wr(12'h01c, 8'h00, 2'h0);
		cmp("pump", 1'h0, pump_on);
		wr(12'h01c, 8'h02, 2'h0);
		cmp("rc", 1'h1, rc_clock_on);
		cmp("pump", 1'h0, pump_on);
		wr(12'h01c, 8'h00, 2'h0);
		cmp("rc", 1'h0, rc_clock_on);
		wr(12'h020, 8'h00, 2'h2);
		rd(12'h1a0, 8'h00, 2'h2);
	endtask : t_regs
	task automatic t_array();
		op(2'h3, 12'h150, 8'h00);
		rd(12'h100, 8'hff, 2'h0);
		rd(12'h19f, 8'hff, 2'h0);
		op(2'h0, 12'h120, 8'ha5);
		rd(12'h120, 8'ha5, 2'h0);
		op(2'h0, 12'h120, 8'h5a);
		rd(12'h120, 8'h00, 2'h0);
		op(2'h0, 12'h121, 8'h00);
		op(2'h1, 12'h120, 8'h00);
		rd(12'h120, 8'hff, 2'h0);
		rd(12'h121, 8'h00, 2'h0);
		op(2'h0, 12'h140, 8'h00);
		op(2'h2, 12'h130, 8'h00);
		rd(12'h121, 8'hff, 2'h0);
		rd(12'h140, 8'h00, 2'h0);
	endtask : t_array
	task automatic t_guard();
		wr(12'h01c, 8'h44, 2'h0);
		wr(12'h100, 8'h00, 2'h0);
		wr(12'h01c, 8'h00, 2'h0);
		wr(12'h01c, 8'h45, 2'h0);
		wr(12'h01c, 8'h00, 2'h0);
		rd(12'h100, 8'hff, 2'h0);
		wr(12'h101, 8'h00, 2'h0);
		wr(12'h01c, 8'h45, 2'h0);
		wr(12'h01c, 8'h00, 2'h0);
		rd(12'h101, 8'hff, 2'h0);
	endtask : t_guard
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs();
		t_array();
		t_guard();
		print_verdict();
	end
endmodule : eeprom_program_erase_control_tb_top
`default_nettype wire
